//--- hdl/otp_seq_pkg.sv
// shared constants, types and helpers for the one-time-programmable memory programming sequencer
package otp_seq_pkg;

  // =========================================================
  // timing
  localparam int CLK_MHZ = 125;                     // pclk rate
  localparam int START_WAIT_US = 20;                // settle time after device reset
  localparam int START_WAIT_CYCLES = START_WAIT_US * CLK_MHZ;
  localparam int GUARD_W = 12;

  // =========================================================
  // link frame: start bit low, two opcode bits, eight payload bits, lsb first
  localparam logic [1:0] OP_ADDR_WR = 2'h0;         // select a link register
  localparam logic [1:0] OP_ADDR_RD = 2'h1;         // returns the status byte
  localparam logic [1:0] OP_DATA_WR = 2'h2;         // write the selected register
  localparam logic [1:0] OP_DATA_RD = 2'h3;         // read the selected register
  localparam logic [3:0] LAST_OP_BIT = 4'h1;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // =========================================================
  // link register selectors
  localparam logic [7:0] SEL_DEVICE_CONTROL = 8'h00;
  localparam logic [7:0] SEL_PROGRAM_CONTROL = 8'h01;
  localparam logic [7:0] SEL_ADDRESS_HIGH = 8'h02;
  localparam logic [7:0] SEL_ADDRESS_LOW = 8'h03;
  localparam logic [7:0] SEL_DATA = 8'h04;
  localparam logic [7:0] SEL_STATUS = 8'h05;

  // =========================================================
  // control codes
  localparam int DEVICE_CONTROL_REG_CORE_RST_BIT = 2;           // 0x04 holds the core
  localparam logic [7:0] DEVICE_CONTROL_REG_RESET_ARM = 8'h02;
  localparam logic [7:0] DEVICE_CONTROL_REG_RESET_FIRE = 8'h00;
  localparam logic [7:0] KEY_ENTER_1 = 8'h40;
  localparam logic [7:0] KEY_ENTER_2 = 8'h4a;
  localparam logic [7:0] KEY_ENTER_2_OLD = 8'h58;
  localparam logic [7:0] KEY_LEAVE_1 = 8'h40;
  localparam logic [7:0] KEY_LEAVE_2 = 8'h00;
  localparam int STAT_BUSY_BIT = 0;                 // link status byte
  localparam int STAT_ERROR_BIT = 1;

  // =========================================================
  // apb register map, byte addresses
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_EVENTS = 8'h04;
  localparam logic [7:0] APB_MASK = 8'h08;
  localparam logic [7:0] APB_STATE = 8'h0c;
  localparam logic [7:0] APB_COUNT = 8'h10;
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int CTRL_LEGACY_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int EV_W = 5;
  localparam int EV_DONE = 0;                       // byte finished
  localparam int EV_ERROR = 1;                      // byte rejected or failed
  localparam int EV_ENTER = 2;                      // program mode entered
  localparam int EV_EXIT = 3;                       // program mode left
  localparam int EV_RESET = 4;                      // device reset requested

  // =========================================================
  // types
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0001,
    MODE_ARMED = 4'b0010,
    MODE_PROG = 4'b0100,
    MODE_LEAVING = 4'b1000
  } mode_type;

  typedef enum logic [3:0] {
    B_IDLE = 4'b0001,
    B_CHECK = 4'b0010,
    B_WRITE = 4'b0100,
    B_WAIT = 4'b1000
  } byte_state_type;

  typedef enum logic [3:0] {
    L_IDLE = 4'b0001,
    L_OP = 4'b0010,
    L_WDATA = 4'b0100,
    L_RDATA = 4'b1000
  } link_state_type;

  // request to the memory macro
  typedef struct packed {
    logic req;
    logic [13:0] addr;
    logic [7:0] wdata;
  } otp_cmd_type;

  // completed link write aimed at one register
  function automatic logic link_wr_hit(input logic stb, input logic [1:0] op,
                                       input logic [7:0] sel, input logic [7:0] tgt);
    link_wr_hit = stb && (op == OP_DATA_WR) && (sel == tgt);
  endfunction

endpackage

//--- hdl/pin_sync.sv
// two-stage synchroniser for the link and voltage pins, with link clock edge detect
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] pins,      // {vpp, data, link clock}
  output logic [2:0] pins_s,
  output logic clk_rise,
  output logic clk_fall
);

  // =========================================================
  // storage
  logic [2:0] meta_r;               // first stage, read only by the second
  logic [2:0] sync_r;
  logic clk_prev_r;                 // delayed synced clock for edges

  // =========================================================
  // synchroniser chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      clk_prev_r <= 1'b0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      clk_prev_r <= sync_r[0];
    end
  end

  // edge detect looks only at the second stage
  assign pins_s = sync_r;
  assign clk_rise = sync_r[0] && !clk_prev_r;
  assign clk_fall = !sync_r[0] && clk_prev_r;

endmodule

//--- hdl/otp_program_sequencer.sv
// debug link programming sequencer for the one-time-programmable program memory
module otp_program_sequencer
  import otp_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk_in,
  input wire logic link_dat_in,
  output logic link_dat_out,
  output logic link_dat_oe,
  input wire logic vpp_present_in,
  output otp_cmd_type otp_cmd,
  input wire logic [7:0] otp_rdata,
  input wire logic otp_done,
  input wire logic otp_fail,
  output logic core_reset,
  output logic device_reset_req,
  output logic irq
);

  // =========================================================
  // pin synchronisation
  logic [2:0] pins_s;               // {vpp, data, clock} after two flops
  logic clk_rise;
  logic clk_fall;
  logic dat_s;
  logic vpp_s;

  pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({vpp_present_in, link_dat_in, link_clk_in}),
    .pins_s(pins_s),
    .clk_rise(clk_rise),
    .clk_fall(clk_fall)
  );

  assign dat_s = pins_s[1];
  assign vpp_s = pins_s[2];

  // =========================================================
  // state
  logic [GUARD_W-1:0] guard_cnt_r;  // counts the post-reset settle time
  logic guard_done_r;
  link_state_type link_state_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] op_r;
  logic [7:0] shift_r;              // incoming payload
  logic [7:0] tx_r;                 // outgoing payload
  logic [7:0] sel_r;                // selected link register
  logic frame_stb_r;                // one cycle after a write frame ends
  logic dat_out_r;
  logic dat_oe_r;
  logic [7:0] device_control_reg_r;
  logic [7:0] progctl_r;
  logic reset_armed_r;
  logic reset_req_r;
  mode_type mode_r;
  logic [15:0] addr_r;              // high:low programming address
  byte_state_type byte_state_r;
  logic [7:0] wdata_r;
  logic [13:0] prog_addr_r;
  logic req_r;
  logic err_r;
  logic [1:0] ctrl_r;
  logic [EV_W-1:0] events_r;
  logic [EV_W-1:0] mask_r;
  logic [15:0] count_r;
  logic [31:0] prdata_r;

  // =========================================================
  // decode of completed link writes
  logic [1:0] op_nxt;
  logic link_go;
  logic wr_device_control_reg;
  logic wr_progctl;
  logic wr_addr_h;
  logic wr_addr_l;
  logic wr_data;
  logic busy;
  logic start_ok;
  logic start_bad;
  logic set_blank_bits;
  logic key2_ok;
  logic [7:0] status_byte;
  logic [7:0] read_byte;
  logic [EV_W-1:0] ev;

  assign op_nxt = {dat_s, op_r[1]};
  assign link_go = guard_done_r && ctrl_r[CTRL_LINK_EN_BIT];
  assign wr_device_control_reg = link_wr_hit(frame_stb_r, op_r, sel_r, SEL_DEVICE_CONTROL);
  assign wr_progctl = link_wr_hit(frame_stb_r, op_r, sel_r, SEL_PROGRAM_CONTROL);
  assign wr_addr_h = link_wr_hit(frame_stb_r, op_r, sel_r, SEL_ADDRESS_HIGH);
  assign wr_addr_l = link_wr_hit(frame_stb_r, op_r, sel_r, SEL_ADDRESS_LOW);
  assign wr_data = link_wr_hit(frame_stb_r, op_r, sel_r, SEL_DATA);
  assign busy = (byte_state_r != B_IDLE);

  // a byte is only programmed in program mode with the voltage present
  assign start_ok = wr_data && !busy && (mode_r == MODE_PROG) && vpp_s;
  assign start_bad = wr_data && !busy && !((mode_r == MODE_PROG) && vpp_s);
  // blank is all ones; a bit once cleared can never be set again
  assign set_blank_bits = |(~otp_rdata & wdata_r);
  // the older second key is honoured only when software allows it
  assign key2_ok = (shift_r == KEY_ENTER_2)
                   || (ctrl_r[CTRL_LEGACY_BIT] && (shift_r == KEY_ENTER_2_OLD));

  // status byte answered to every address read
  assign status_byte = {6'h00, err_r, busy};

  // readback of the selected register; data reads the memory itself
  assign read_byte = (sel_r == SEL_DEVICE_CONTROL) ? device_control_reg_r :
                     (sel_r == SEL_PROGRAM_CONTROL) ? progctl_r :
                     (sel_r == SEL_ADDRESS_HIGH) ? addr_r[15:8] :
                     (sel_r == SEL_ADDRESS_LOW) ? addr_r[7:0] :
                     (sel_r == SEL_DATA) ? otp_rdata :
                     (sel_r == SEL_STATUS) ? status_byte : 8'h00;

  // =========================================================
  // events
  assign ev[EV_DONE] = (byte_state_r == B_WAIT) && otp_done;
  assign ev[EV_ERROR] = start_bad || ((byte_state_r == B_CHECK) && set_blank_bits)
                        || ((byte_state_r == B_WAIT) && otp_done && otp_fail);
  assign ev[EV_ENTER] = wr_progctl && (mode_r == MODE_ARMED) && key2_ok;
  assign ev[EV_EXIT] = wr_progctl && (mode_r == MODE_LEAVING) && (shift_r == KEY_LEAVE_2);
  assign ev[EV_RESET] = wr_device_control_reg && reset_armed_r && (shift_r == DEVICE_CONTROL_REG_RESET_FIRE);

  // =========================================================
  // settle guard after device reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_cnt_r <= '0;
      guard_done_r <= 1'b0;
    end else if (!guard_done_r) begin
      guard_cnt_r <= guard_cnt_r + 1'b1;
      guard_done_r <= (guard_cnt_r == GUARD_W'(START_WAIT_CYCLES - 1));
    end
  end

  // =========================================================
  // link frame receiver and transmitter, all on synced clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_state_r <= L_IDLE;
      bit_cnt_r <= 4'h0;
      op_r <= 2'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      frame_stb_r <= 1'b0;
      dat_out_r <= 1'b0;
      dat_oe_r <= 1'b0;
    end else begin
      frame_stb_r <= 1'b0;
      unique case (link_state_r)
        L_IDLE: begin
          // start bit: data low at a clock rise
          if (link_go && clk_rise && !dat_s) begin
            link_state_r <= L_OP;
            bit_cnt_r <= 4'h0;
          end
        end
        L_OP: begin
          if (clk_rise) begin
            op_r <= op_nxt;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == LAST_OP_BIT) begin
              bit_cnt_r <= 4'h0;
              if (op_nxt[0]) begin
                // reads: address read gives status, data read the selection
                tx_r <= (op_nxt == OP_ADDR_RD) ? status_byte : read_byte;
                link_state_r <= L_RDATA;
              end else begin
                link_state_r <= L_WDATA;
              end
            end
          end
        end
        L_WDATA: begin
          if (clk_rise) begin
            shift_r <= {dat_s, shift_r[7:1]};
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == LAST_DATA_BIT) begin
              frame_stb_r <= 1'b1;
              link_state_r <= L_IDLE;
            end
          end
        end
        L_RDATA: begin
          // drive on falling edges so the programmer samples on rising ones
          if (clk_fall) begin
            dat_out_r <= tx_r[0];
            tx_r <= {1'b0, tx_r[7:1]};
            dat_oe_r <= 1'b1;
          end
          if (clk_rise) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == LAST_DATA_BIT) begin
              dat_oe_r <= 1'b0;
              link_state_r <= L_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign link_dat_out = dat_out_r;
  assign link_dat_oe = dat_oe_r;

  // =========================================================
  // register selection from address-write frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= SEL_STATUS;
    end else if (frame_stb_r && (op_r == OP_ADDR_WR)) begin
      sel_r <= shift_r;
    end
  end

  // =========================================================
  // device control: core hold and two-step device reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_control_reg_r <= 8'h00;
      reset_armed_r <= 1'b0;
      reset_req_r <= 1'b0;
    end else begin
      reset_req_r <= ev[EV_RESET];
      if (wr_device_control_reg) begin
        device_control_reg_r <= shift_r;
        // any other value breaks the arming pair
        reset_armed_r <= (shift_r == DEVICE_CONTROL_REG_RESET_ARM);
      end
    end
  end

  assign core_reset = device_control_reg_r[DEVICE_CONTROL_REG_CORE_RST_BIT];
  assign device_reset_req = reset_req_r;

  // =========================================================
  // program mode key sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_OFF;
      progctl_r <= 8'h00;
    end else if (reset_req_r) begin
      mode_r <= MODE_OFF;
    end else if (wr_progctl) begin
      progctl_r <= shift_r;
      unique case (mode_r)
        MODE_OFF: begin
          // entry needs the core held so it cannot fetch mid-program
          if ((shift_r == KEY_ENTER_1) && core_reset) begin
            mode_r <= MODE_ARMED;
          end
        end
        MODE_ARMED: begin
          mode_r <= ev[EV_ENTER] ? MODE_PROG : MODE_OFF;
        end
        MODE_PROG: begin
          if (shift_r == KEY_LEAVE_1) begin
            mode_r <= MODE_LEAVING;
          end
        end
        MODE_LEAVING: begin
          mode_r <= ev[EV_EXIT] ? MODE_OFF : MODE_PROG;
        end
      endcase
    end
  end

  // =========================================================
  // programming address, loaded in halves and stepped per byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 16'h0000;
    end else if (wr_addr_h) begin
      addr_r[15:8] <= shift_r;
    end else if (wr_addr_l) begin
      addr_r[7:0] <= shift_r;
    end else if (start_ok) begin
      addr_r <= addr_r + 16'h0001;
    end
  end

  // =========================================================
  // byte programming engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_state_r <= B_IDLE;
      wdata_r <= 8'hff;
      prog_addr_r <= 14'h0000;
      req_r <= 1'b0;
    end else begin
      req_r <= 1'b0;
      unique case (byte_state_r)
        B_IDLE: begin
          // idle address follows the pointer so data reads see it
          prog_addr_r <= addr_r[13:0];
          if (start_ok) begin
            wdata_r <= shift_r;
            byte_state_r <= B_CHECK;
          end
        end
        B_CHECK: begin
          if (set_blank_bits) begin
            byte_state_r <= B_IDLE;
          end else begin
            req_r <= 1'b1;
            byte_state_r <= B_WRITE;
          end
        end
        B_WRITE: begin
          byte_state_r <= B_WAIT;
        end
        B_WAIT: begin
          if (otp_done) begin
            byte_state_r <= B_IDLE;
          end
        end
      endcase
    end
  end

  assign otp_cmd = '{req: req_r, addr: prog_addr_r, wdata: wdata_r};

  // =========================================================
  // error bit seen by the programmer, cleared on mode entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (ev[EV_ERROR]) begin
      err_r <= 1'b1;
    end else if (ev[EV_ENTER]) begin
      err_r <= 1'b0;
    end
  end

  // =========================================================
  // apb slave: zero wait states, read data captured in setup
  logic apb_setup;
  logic apb_wr;
  logic apb_hit;
  logic [31:0] apb_rd;

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && apb_hit;
  assign apb_hit = (paddr == APB_CTRL) || (paddr == APB_EVENTS) || (paddr == APB_MASK)
                   || (paddr == APB_STATE) || (paddr == APB_COUNT);
  // no path into the memory exists from this bus
  assign apb_rd = (paddr == APB_CTRL) ? {30'h0, ctrl_r} :
                  (paddr == APB_EVENTS) ? {27'h0, events_r} :
                  (paddr == APB_MASK) ? {27'h0, mask_r} :
                  (paddr == APB_STATE) ? {8'h0, core_reset, vpp_s, busy, err_r,
                                          mode_r, addr_r} :
                  (paddr == APB_COUNT) ? {16'h0, count_r} : 32'h0;

  // register writes, sticky events with set beating clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      mask_r <= '0;
      events_r <= '0;
      count_r <= 16'h0000;
      prdata_r <= 32'h0;
    end else begin
      if (apb_setup) begin
        prdata_r <= apb_rd;
      end
      if (apb_wr && (paddr == APB_CTRL)) begin
        ctrl_r <= pwdata[1:0];
      end
      if (apb_wr && (paddr == APB_MASK)) begin
        mask_r <= pwdata[EV_W-1:0];
      end
      if (apb_wr && (paddr == APB_EVENTS)) begin
        events_r <= (events_r & ~pwdata[EV_W-1:0]) | ev;
      end else begin
        events_r <= events_r | ev;
      end
      if (ev[EV_DONE] && !otp_fail) begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign irq = |(events_r & mask_r);

endmodule

//--- verif/otp_seq_checker.sv
// port-level assertions for the programming sequencer
module otp_seq_checker
  import otp_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire otp_cmd_type otp_cmd,
  input wire logic core_reset,
  input wire logic device_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // decode
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable; // access phase
  wire hit = (paddr <= APB_COUNT) && (paddr[1:0] == 2'h0); // mapped word
  // ==========
  // checks
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && hit |-> !pslverr) else $error("mapped refused");
  a_err_in_access: assert property (pslverr |-> acc) else $error("stray slverr");
  a_req_spaced: assert property (otp_cmd.req |=> !otp_cmd.req [*8])
    else $error("byte requests too close");
  a_req_core_held: assert property (otp_cmd.req |-> core_reset)
    else $error("byte written with core running");
  a_reset_pulse: assert property (device_reset_req |=> !device_reset_req)
    else $error("reset request too long");
  a_reset_core_free: assert property (device_reset_req |-> !core_reset)
    else $error("core still held at reset");
  c_byte: cover property (otp_cmd.req);
  c_reset: cover property (device_reset_req);
  c_refused: cover property (acc && pslverr);
endmodule

bind otp_program_sequencer otp_seq_checker chk_u (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .otp_cmd(otp_cmd), .core_reset(core_reset),
  .device_reset_req(device_reset_req));

//--- verif/link_programmer.sv
// behavioural external programmer on the debug link
module link_programmer
  import otp_seq_pkg::*;
(
  input wire logic line,
  output logic link_clk,
  output logic drv,
  output logic vpp
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // bit level, 125 ns link period
  // clock stands low between frames; released data sits at the pull-up level
  initial begin
    link_clk = 1'b0;
    drv = 1'b1;
    vpp = 1'b0;
  end
  task automatic bit_out(input logic b);
    drv = b;
    #62 link_clk = 1'b1;
    #63 link_clk = 1'b0;
  endtask
  // device drives after the fall, so sample just at the rise
  task automatic bit_in(output logic b);
    drv = 1'b1;
    #62 b = line;
    link_clk = 1'b1;
    #63 link_clk = 1'b0;
  endtask
  // ==========
  // frames, the only path to the memory
  task automatic frame(input logic [1:0] op, input logic [7:0] wd, output logic [7:0] rd);
    rd = 8'h00;
    bit_out(1'b0);
    bit_out(op[0]);
    bit_out(op[1]);
    for (int i = 0; i < 8; i++) begin
      if (op[0]) bit_in(rd[i]);
      else bit_out(wd[i]);
    end
    drv = 1'b1;
    #125; // one quiet link period between frames
  endtask
  task automatic reg_wr(input logic [7:0] sel, input logic [7:0] v);
    logic [7:0] d;
    frame(OP_ADDR_WR, sel, d);
    frame(OP_DATA_WR, v, d);
  endtask
  task automatic reg_rd(input logic [7:0] sel, output logic [7:0] v);
    logic [7:0] d;
    frame(OP_ADDR_WR, sel, d);
    frame(OP_DATA_RD, 8'h00, v);
  endtask
  task automatic status(output logic [7:0] v);
    frame(OP_ADDR_RD, 8'h00, v);
  endtask
  task automatic set_vpp(input logic on);
    vpp = on;
    #250;
  endtask
endmodule

//--- verif/test_otp_program_sequencer.sv
// self-checking bench for the programming sequencer
module test_otp_program_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import otp_seq_pkg::*;
  // ==========
  // signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, dat_out, dat_oe, core_reset, rst_req, irq, otp_done = 1'b0;
  logic link_clk, drv, vpp;
  otp_cmd_type otp_cmd, last_cmd;
  logic [7:0] mem [0:16383]; // memory macro contents
  int n_fail = 0, compares = 0, n_req = 0, n_rst = 0, cyc = 0, wait_cnt = 0;
  wire line = dat_oe ? dat_out : drv; // resolved data wire
  initial forever #4 pclk = ~pclk;
  otp_program_sequencer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk_in(link_clk), .link_dat_in(line), .link_dat_out(dat_out),
    .link_dat_oe(dat_oe), .vpp_present_in(vpp), .otp_cmd(otp_cmd), .otp_rdata(mem[otp_cmd.addr]),
    .otp_done(otp_done), .otp_fail(1'b0), .core_reset(core_reset),
    .device_reset_req(rst_req), .irq(irq));
  link_programmer prog_u (.line(line), .link_clk(link_clk), .drv(drv), .vpp(vpp));
  // ==========
  // memory macro, slow enough that polling sees busy
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(posedge pclk) begin
    otp_done <= (wait_cnt == 1);
    wait_cnt <= otp_cmd.req ? 300 : (wait_cnt > 0 ? wait_cnt - 1 : 0);
    if (otp_cmd.req) begin
      n_req <= n_req + 1;
      last_cmd <= otp_cmd;
    end
    if (wait_cnt == 1) mem[last_cmd.addr] <= last_cmd.wdata;
    if (rst_req) n_rst <= n_rst + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic apb_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] d;
    logic e;
    apb(a, 1'b0, 32'h0, d, e);
    chk(d, exp);
    chk(e, experr);
  endtask
  task automatic apb_wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(a, 1'b1, wd, d, e);
  endtask
  // write a byte, poll till idle, then see what reached the macro
  task automatic byte_wr(input logic [7:0] d, input logic [13:0] a);
    logic [7:0] s;
    prog_u.reg_wr(SEL_DATA, d);
    prog_u.status(s);
    chk(s[STAT_BUSY_BIT], 1'b1);
    repeat (20) if (s[STAT_BUSY_BIT]) prog_u.status(s);
    chk(s[1:0], 2'h0);
    chk({last_cmd.addr, last_cmd.wdata}, {a, d});
  endtask
  task final_report;
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    logic [7:0] s;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb_chk(APB_CTRL, 32'h1, 1'b0);
    apb_chk(APB_STATE, 32'h0001_0000, 1'b0);
    apb_chk(8'h14, 32'h0, 1'b1);
    apb_wr(APB_MASK, 32'h1f);
    prog_u.reg_wr(SEL_DEVICE_CONTROL, 8'h04);
    chk(core_reset, 1'b0);
    repeat (START_WAIT_CYCLES) @(posedge pclk);
    prog_u.reg_wr(SEL_DEVICE_CONTROL, 8'h04);
    chk(core_reset, 1'b1);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_ENTER_2);
    apb_chk(APB_STATE, 32'h0081_0000, 1'b0);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_ENTER_1);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_ENTER_2);
    apb_chk(APB_STATE, 32'h0084_0000, 1'b0);
    prog_u.set_vpp(1'b1);
    prog_u.reg_wr(SEL_ADDRESS_HIGH, 8'h00);
    prog_u.reg_wr(SEL_ADDRESS_LOW, 8'h10);
    byte_wr(8'h5a, 14'h10);
    byte_wr(8'h0f, 14'h11);
    prog_u.reg_wr(SEL_ADDRESS_LOW, 8'h10);
    prog_u.reg_wr(SEL_DATA, 8'ha5);
    prog_u.status(s);
    repeat (20) if (s[STAT_BUSY_BIT]) prog_u.status(s);
    chk(s[1:0], 2'h2);
    chk(n_req, 2);
    prog_u.reg_rd(SEL_ADDRESS_LOW, s);
    chk(s, 8'h11);
    apb_chk(APB_COUNT, 32'h2, 1'b0);
    apb_chk(APB_EVENTS, 32'h7, 1'b0);
    chk(irq, 1'b1);
    apb_wr(APB_MASK, 32'h0);
    @(posedge pclk); // mask settles only after the access edge
    chk(irq, 1'b0);
    apb_wr(APB_EVENTS, 32'h1f);
    apb_chk(APB_EVENTS, 32'h0, 1'b0);
    prog_u.set_vpp(1'b0);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_LEAVE_1);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_LEAVE_2);
    apb_chk(APB_EVENTS, 32'h8, 1'b0);
    // older second key refused until software allows it, error bit still set
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_ENTER_1);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_ENTER_2_OLD);
    apb_chk(APB_STATE, 32'h0091_0011, 1'b0);
    apb_wr(APB_CTRL, 32'h3);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_ENTER_1);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_ENTER_2_OLD);
    apb_chk(APB_STATE, 32'h0084_0011, 1'b0);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_LEAVE_1);
    prog_u.reg_wr(SEL_PROGRAM_CONTROL, KEY_LEAVE_2);
    apb_chk(APB_STATE, 32'h0081_0011, 1'b0);
    prog_u.reg_wr(SEL_DEVICE_CONTROL, DEVICE_CONTROL_REG_RESET_ARM);
    prog_u.reg_wr(SEL_DEVICE_CONTROL, DEVICE_CONTROL_REG_RESET_FIRE);
    chk(n_rst, 1);
    chk(core_reset, 1'b0);
    final_report;
  end
endmodule
